// ==== dcfc_pkg.sv ====
// Purpose: Shared constants for the dual-clock FIFO control and cascade block
// Assumes: One clock (pclk); both FIFO sides run on it; APB register access
// Notes:   Register offsets are byte addresses on a 32-bit APB bus

package dcfc_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] CNT_OFF  = 8'h08;

    // Control register fields
    localparam int          CTRL_SLEEP_BIT = 0;
    localparam int          CTRL_CSEL_BIT  = 1;
    localparam int          CTRL_POS_LSB   = 2;
    localparam int          CTRL_MODE_LSB  = 5;
    localparam logic [31:0] CTRL_RST_VAL   = 32'h0000_0000;

    // Status register fields
    localparam int STAT_WBUSY_BIT = 0;
    localparam int STAT_RBUSY_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;
    localparam int STAT_FULL_BIT  = 3;
    localparam int STAT_SLEEP_BIT = 4;

    // Count register: level count low, word count high
    localparam int CNT_HI_LSB = 16;

    // Chain positions
    localparam logic [2:0] POS_NONE     = 3'h0;
    localparam logic [2:0] POS_FIRST    = 3'h1;
    localparam logic [2:0] POS_MIDDLE   = 3'h2;
    localparam logic [2:0] POS_LAST     = 3'h3;
    localparam logic [2:0] POS_PARALLEL = 3'h4;

    // Output register modes
    localparam logic [1:0] MODE_UNREG = 2'h0;
    localparam logic [1:0] MODE_REG   = 2'h1;
    localparam logic [1:0] MODE_PIPE  = 2'h2;

    // Level count select
    localparam logic CSEL_PTR   = 1'b0;
    localparam logic CSEL_COUNT = 1'b1;

    // Reset busy lengths in pclk cycles: write side after reset release, read tail after write busy ends
    localparam logic [3:0] WR_BUSY_CYC = 4'h4;
    localparam logic [3:0] RD_TAIL_CYC = 4'h2;

    // Reset sequencer states
    typedef enum logic [2:0] {
        DCFC_ST_RUN   = 3'b001,
        DCFC_ST_HOLD  = 3'b010,
        DCFC_ST_DRAIN = 3'b100
    } dcfc_rst_state_t;

endpackage

// ==== dcfc_ctrl_cascade.sv ====
// Purpose: FIFO control, reset busy, error flags, output stage and cascade ports
// Assumes: All user and chain inputs come from logic on pclk
// Notes:   Control lives in an APB register; read and write sides share pclk
`timescale 1ns/10ps
`default_nettype none

module dcfc_ctrl_cascade #(
    parameter int DATA_W  = 64,
    parameter int PAR_W   = 8,
    parameter int ADDR_W  = 9,
    parameter int COUNT_W = 14
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                fifo_reset,
    input  wire logic                write_enable,
    input  wire logic [DATA_W-1:0]   write_data,
    input  wire logic [PAR_W-1:0]    write_parity,
    input  wire logic                read_enable,
    output logic      [DATA_W-1:0]   read_data,
    output logic      [PAR_W-1:0]    read_parity,
    output logic                     fifo_empty,
    output logic                     fifo_full,
    output logic                     write_reset_busy,
    output logic                     read_reset_busy,
    output logic                     write_error_flag,
    output logic                     read_error_flag,
    output logic      [COUNT_W-1:0]  write_level_count,
    input  wire logic                out_reg_clock_en,
    input  wire logic                out_reg_reset,
    input  wire logic [DATA_W-1:0]   chain_data_in,
    input  wire logic [PAR_W-1:0]    chain_parity_in,
    output logic      [DATA_W-1:0]   chain_data_out,
    output logic      [PAR_W-1:0]    chain_parity_out,
    input  wire logic                upstream_empty_in,
    output logic                     upstream_read_req,
    input  wire logic                downstream_read_req,
    output logic                     downstream_empty_out,
    input  wire logic                outreg_mux_sel_d,
    input  wire logic                outreg_mux_sel_en,
    input  wire logic                ram_mux_sel_d,
    input  wire logic                ram_mux_sel_en
);

    localparam int WORD_W = DATA_W + PAR_W;
    localparam int PTR_W  = ADDR_W + 1;
    localparam logic [PTR_W-1:0] FULL_CNT = {1'b1, {ADDR_W{1'b0}}};

    // True when position p is one of three listed positions
    function automatic logic pos_is(input logic [2:0] p, input logic [2:0] a,
                                    input logic [2:0] b, input logic [2:0] c);
        pos_is = (p == a) || (p == b) || (p == c);
    endfunction

    // Zero-extend a pointer-sized value onto the count width
    function automatic logic [COUNT_W-1:0] widen(input logic [PTR_W-1:0] v);
        widen = COUNT_W'(v);
    endfunction

    logic [31:0]                  ctrl_reg;
    dcfc_pkg::dcfc_rst_state_t    rst_state_reg;
    dcfc_pkg::dcfc_rst_state_t    rst_state_next;
    logic [3:0]                   rst_cnt_reg;
    logic [3:0]                   rd_tail_reg;
    logic [PTR_W-1:0]             wr_ptr_reg;
    logic [PTR_W-1:0]             rd_ptr_reg;
    logic [WORD_W-1:0]            mem [1 << ADDR_W];
    logic [WORD_W-1:0]            ram_q_reg;
    logic [WORD_W-1:0]            out_reg;
    logic                         rd_done_reg;
    logic                         pend_reg;
    logic                         ram_sel_reg;
    logic                         oreg_sel_reg;
    logic                         wr_err_reg;
    logic                         rd_err_reg;
    logic [COUNT_W-1:0]           wcount_reg;

    // Control field decode
    wire logic       sleep_on  = ctrl_reg[dcfc_pkg::CTRL_SLEEP_BIT];
    wire logic       count_sel = ctrl_reg[dcfc_pkg::CTRL_CSEL_BIT];
    wire logic [2:0] chain_pos = ctrl_reg[dcfc_pkg::CTRL_POS_LSB +: 3];
    wire logic [1:0] reg_mode  = ctrl_reg[dcfc_pkg::CTRL_MODE_LSB +: 2];
    wire logic       pipe_mode = (reg_mode == dcfc_pkg::MODE_PIPE);
    wire logic       parallel  = (chain_pos == dcfc_pkg::POS_PARALLEL);

    // Chain roles; each gates its own ports so unused ones are ignored
    wire logic pull_en   = pos_is(chain_pos, dcfc_pkg::POS_MIDDLE,
                                  dcfc_pkg::POS_LAST, dcfc_pkg::POS_LAST);
    wire logic sink_en   = pos_is(chain_pos, dcfc_pkg::POS_FIRST,
                                  dcfc_pkg::POS_MIDDLE, dcfc_pkg::POS_MIDDLE);
    wire logic take_in   = pos_is(chain_pos, dcfc_pkg::POS_MIDDLE,
                                  dcfc_pkg::POS_LAST, dcfc_pkg::POS_PARALLEL);
    wire logic drive_out = pos_is(chain_pos, dcfc_pkg::POS_FIRST,
                                  dcfc_pkg::POS_MIDDLE, dcfc_pkg::POS_PARALLEL);

    // Occupancy from wrap-extended pointers
    wire logic [PTR_W-1:0] data_count = wr_ptr_reg - rd_ptr_reg;
    wire logic             full_w     = (data_count == FULL_CNT);
    wire logic             empty_w    = (data_count == '0);
    wire logic             wr_busy    = (rst_state_reg != dcfc_pkg::DCFC_ST_RUN);
    wire logic             rd_busy    = wr_busy || (rd_tail_reg != '0);

    // Gated chain input word; zero when this position takes nothing
    wire logic [WORD_W-1:0] chain_word_in = take_in ?
                                            {chain_parity_in, chain_data_in} : '0;

    // Write side: serial MIDDLE/LAST fills from upstream, otherwise user
    wire logic              wr_req  = pull_en ? pend_reg : write_enable;
    wire logic [WORD_W-1:0] wr_word = pull_en ? chain_word_in
                                              : {write_parity, write_data};
    wire logic              wr_fail = wr_req && (wr_busy || full_w || sleep_on);
    wire logic              wr_ok   = wr_req && !wr_fail;

    // Read side: serial FIRST/MIDDLE is drained by the next FIFO
    wire logic rd_req  = sink_en ? downstream_read_req : read_enable;
    wire logic rd_fail = rd_req && (rd_busy || empty_w || sleep_on);
    wire logic rd_ok   = rd_req && !rd_fail;

    // Pull only with room for the word already in flight, so no overflow
    wire logic [PTR_W-1:0] committed = PTR_W'(data_count + PTR_W'(pend_reg));
    assign upstream_read_req = pull_en && !upstream_empty_in && !wr_busy
                               && !sleep_on && (committed < FULL_CNT);
    // Empty reads high when not a serial source: nothing is offered
    assign downstream_empty_out = sink_en ? empty_w : 1'b1;

    // Cascade muxes ahead of and behind the output stage
    wire logic [WORD_W-1:0] ram_mux_word = (parallel && ram_sel_reg)
                                           ? chain_word_in : ram_q_reg;
    wire logic [WORD_W-1:0] pipe_in = (pipe_mode && parallel && oreg_sel_reg)
                                      ? chain_word_in : ram_mux_word;
    wire logic [WORD_W-1:0] out_word = (reg_mode == dcfc_pkg::MODE_UNREG)
                                       ? ram_mux_word : out_reg;

    assign read_data         = out_word[DATA_W-1:0];
    assign read_parity       = out_word[WORD_W-1 -: PAR_W];
    assign chain_data_out    = drive_out ? ram_mux_word[DATA_W-1:0] : '0;
    assign chain_parity_out  = drive_out ? ram_mux_word[WORD_W-1 -: PAR_W] : '0;
    assign fifo_empty        = empty_w;
    assign fifo_full         = full_w;
    assign write_reset_busy  = wr_busy;
    assign read_reset_busy   = rd_busy;
    assign write_error_flag  = wr_err_reg;
    assign read_error_flag   = rd_err_reg;
    assign write_level_count = wcount_reg;

    // APB decode; zero-wait slave, unmapped addresses answer with an error
    wire logic hit_ctrl = (paddr == dcfc_pkg::CTRL_OFF);
    wire logic hit_stat = (paddr == dcfc_pkg::STAT_OFF);
    wire logic hit_cnt  = (paddr == dcfc_pkg::CNT_OFF);
    wire logic apb_acc  = psel && penable;
    wire logic ctrl_wr  = apb_acc && pwrite && hit_ctrl;

    assign pready  = 1'b1;
    assign pslverr = apb_acc && !(hit_ctrl || hit_stat || hit_cnt);

    // Read mux; unused status and count bits read as zero, control reads back all 32 written bits
    always_comb begin
        prdata = '0;
        if (hit_ctrl) begin
            prdata = ctrl_reg;
        end else if (hit_stat) begin
            prdata[dcfc_pkg::STAT_WBUSY_BIT] = wr_busy;
            prdata[dcfc_pkg::STAT_RBUSY_BIT] = rd_busy;
            prdata[dcfc_pkg::STAT_EMPTY_BIT] = empty_w;
            prdata[dcfc_pkg::STAT_FULL_BIT]  = full_w;
            prdata[dcfc_pkg::STAT_SLEEP_BIT] = sleep_on;
        end else if (hit_cnt) begin
            prdata[COUNT_W-1:0] = wcount_reg;
            prdata[dcfc_pkg::CNT_HI_LSB +: COUNT_W] = widen(data_count);
        end
    end

    // Control register, written only in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= dcfc_pkg::CTRL_RST_VAL;
        end else if (ctrl_wr) begin
            ctrl_reg <= pwdata;
        end
    end

    // Reset sequencer: busy while reset is held and a few cycles after.
    // The reset input is used unsynchronised, as it shares pclk.
    always_comb begin
        rst_state_next = rst_state_reg;
        case (rst_state_reg)
            dcfc_pkg::DCFC_ST_RUN: begin
                if (fifo_reset) rst_state_next = dcfc_pkg::DCFC_ST_HOLD;
            end
            dcfc_pkg::DCFC_ST_HOLD: begin
                if (!fifo_reset) rst_state_next = dcfc_pkg::DCFC_ST_DRAIN;
            end
            dcfc_pkg::DCFC_ST_DRAIN: begin
                if (fifo_reset) begin
                    rst_state_next = dcfc_pkg::DCFC_ST_HOLD;
                end else if (rst_cnt_reg == dcfc_pkg::WR_BUSY_CYC - 4'h1) begin
                    rst_state_next = dcfc_pkg::DCFC_ST_RUN;
                end
            end
            default: rst_state_next = dcfc_pkg::DCFC_ST_HOLD;
        endcase
    end

    // Power-up behaves like a reset release, so busy shows first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_state_reg <= dcfc_pkg::DCFC_ST_DRAIN;
            rst_cnt_reg   <= '0;
        end else begin
            rst_state_reg <= rst_state_next;
            rst_cnt_reg   <= (rst_state_reg == dcfc_pkg::DCFC_ST_DRAIN)
                             ? rst_cnt_reg + 4'h1 : '0;
        end
    end

    // Read side leaves reset after the write side, as a crossing would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_tail_reg <= dcfc_pkg::RD_TAIL_CYC;
        end else if (wr_busy) begin
            rd_tail_reg <= dcfc_pkg::RD_TAIL_CYC;
        end else if (rd_tail_reg != '0) begin
            rd_tail_reg <= rd_tail_reg - 4'h1;
        end
    end

    // Pointers clear while the FIFO is in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (wr_busy) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(wr_ok);
            rd_ptr_reg <= rd_ptr_reg + PTR_W'(rd_ok);
        end
    end

    // Array storage; no write or read while asleep, so the array idles
    always_ff @(posedge pclk) begin
        if (wr_ok) begin
            mem[wr_ptr_reg[ADDR_W-1:0]] <= wr_word;
        end
    end

    // Array output latch, cleared by the FIFO reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_q_reg   <= '0;
            rd_done_reg <= 1'b0;
        end else begin
            if (wr_busy) begin
                ram_q_reg <= '0;
            end else if (rd_ok) begin
                ram_q_reg <= mem[rd_ptr_reg[ADDR_W-1:0]];
            end
            rd_done_reg <= rd_ok;
        end
    end

    // Cascade select flops, loaded only in the modes that use them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_sel_reg  <= 1'b0;
            oreg_sel_reg <= 1'b0;
        end else begin
            if (parallel && ram_mux_sel_en) ram_sel_reg <= ram_mux_sel_d;
            if (pipe_mode && parallel && outreg_mux_sel_en) begin
                oreg_sel_reg <= outreg_mux_sel_d;
            end
        end
    end

    // Output stage: external controls in pipeline mode, reset wins over enable;
    // in registered mode the controller loads it one cycle after a read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= '0;
        end else if (pipe_mode) begin
            if (out_reg_reset) begin
                out_reg <= '0;
            end else if (out_reg_clock_en) begin
                out_reg <= pipe_in;
            end
        end else if (wr_busy) begin
            out_reg <= '0;
        end else if (reg_mode == dcfc_pkg::MODE_REG && rd_done_reg) begin
            out_reg <= ram_mux_word;
        end
    end

    // Error pulses, in-flight pull marker and level count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_err_reg <= 1'b0;
            rd_err_reg <= 1'b0;
            pend_reg   <= 1'b0;
            wcount_reg <= '0;
        end else begin
            wr_err_reg <= wr_fail;
            rd_err_reg <= rd_fail;
            pend_reg   <= upstream_read_req;
            wcount_reg <= (count_sel == dcfc_pkg::CSEL_COUNT)
                          ? widen(data_count) : widen(wr_ptr_reg);
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_reset_drop;
        $fell(fifo_reset);
    endsequence

    sequence s_quiet_five;
        (!fifo_reset) [*5];
    endsequence

    a_wr_busy_enter: assert property (fifo_reset |=> write_reset_busy)
        else $error("write busy not raised under reset");
    a_wr_busy_leave: assert property (s_reset_drop ##1 s_quiet_five |->
        !write_reset_busy && $past(write_reset_busy))
        else $error("write busy released at wrong cycle");
    a_rd_busy_cover: assert property (write_reset_busy |-> read_reset_busy)
        else $error("read busy low while write side in reset");
    a_rd_busy_tail: assert property ($fell(write_reset_busy) && !fifo_reset
        |-> read_reset_busy ##1 read_reset_busy ##1 !read_reset_busy)
        else $error("read busy tail length wrong");
    a_rd_busy_err: assert property (rd_req && read_reset_busy |=> read_error_flag)
        else $error("read during busy not flagged");
    a_wr_busy_err: assert property (wr_req && write_reset_busy |=> write_error_flag)
        else $error("write during busy not flagged");
    // Busy is left out: the reset clears the pointers on its own
    a_wr_full_err: assert property (wr_req && fifo_full && !write_reset_busy
        |=> write_error_flag
        && $stable(wr_ptr_reg))
        else $error("write into full FIFO not refused");
    a_wr_accept: assert property (wr_req && !write_reset_busy && !fifo_full
        && !sleep_on |=> wr_ptr_reg == $past(wr_ptr_reg) + PTR_W'(1) && !write_error_flag)
        else $error("good write not accepted");
    a_level_count: assert property (count_sel == dcfc_pkg::CSEL_COUNT
        && $stable(count_sel) |-> write_level_count == widen($past(data_count)))
        else $error("level count does not follow occupancy");
    a_pipe_load: assert property (pipe_mode && out_reg_clock_en && !out_reg_reset
        && $stable(ctrl_reg) |=> out_reg == $past(pipe_in))
        else $error("output stage not loaded on enable");
    // Stage itself is checked, so a mode change next cycle cannot confuse it
    a_pipe_reset: assert property (pipe_mode && out_reg_reset |=> out_reg == '0)
        else $error("output stage not reset");
    a_ram_sel_load: assert property (parallel && ram_mux_sel_en
        |=> ram_sel_reg == $past(ram_mux_sel_d))
        else $error("memory mux select not loaded");
    a_oreg_sel_load: assert property (pipe_mode && parallel && outreg_mux_sel_en
        |=> oreg_sel_reg == $past(outreg_mux_sel_d))
        else $error("output mux select not loaded");
    a_sleep_idle: assert property (sleep_on |=> $stable(wr_ptr_reg)
        && $stable(rd_ptr_reg) || write_reset_busy)
        else $error("array accessed while asleep");
    a_chain_idle: assert property (!drive_out |-> chain_data_out == '0
        && downstream_empty_out && (pull_en || !upstream_read_req))
        else $error("unused chain output not inactive");
    a_pull_gate: assert property (upstream_read_req |-> pull_en
        && !upstream_empty_in ##1 pend_reg)
        else $error("upstream request without data offered");
    a_rd_empty_err: assert property (rd_req && fifo_empty |=> read_error_flag
        && $stable(rd_ptr_reg))
        else $error("read of empty FIFO not flagged");

endmodule // dcfc_ctrl_cascade

`default_nettype wire

// ==== dcfc_up_model.sv ====
// Purpose: Upstream chained FIFO model feeding the chain inputs
// Assumes: One word pulled per request on pclk
// Notes:   Idle data lines toggle so a stale word never passes for a fresh one
`timescale 1ns/10ps
`default_nettype none
module dcfc_up_model #(parameter int WORDS = 3) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        upstream_read_req,
    output logic      [63:0] chain_data_in,
    output logic      [7:0]  chain_parity_in,
    output logic             upstream_empty_in
);
    int left;
    // Own empty state seen by the chained neighbour
    assign upstream_empty_in = (left == 0);
    assign chain_parity_in = chain_data_in[7:0];
    // Word shows the cycle after a request, otherwise the bus toggles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= WORDS;
            chain_data_in <= 64'h0;
        end else if (upstream_read_req && left != 0) begin
            left <= left - 1;
            chain_data_in <= {32'hC0DE_0000, 32'(left)};
        end else begin
            chain_data_in <= ~chain_data_in;
        end
    end
endmodule // dcfc_up_model
`default_nettype wire

// ==== tb_dcfc_ctrl_cascade.sv ====
// Purpose: Self-checking bench for the FIFO control and cascade block
// Assumes: One pclk for both FIFO sides
// Notes:   Random words from an xorshift seeded at 94
`timescale 1ns/10ps
`default_nettype none
module tb_dcfc_ctrl_cascade;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h00, write_parity = 8'h00, read_parity, chain_parity_in;
    logic [7:0]  chain_parity_out;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000_005E;
    logic        pready, pslverr, fifo_reset = 0, write_enable = 0, read_enable = 0;
    logic [63:0] write_data = 64'h0, read_data, chain_data_in, chain_data_out;
    logic        fifo_empty, fifo_full, write_reset_busy, read_reset_busy, downstream_empty_out;
    logic        write_error_flag, read_error_flag, upstream_empty_in, upstream_read_req;
    logic [6:0]  misc = 7'h00;
    logic [13:0] write_level_count;
    logic [63:0] words [4];
    int          mismatches = 0, n_compared = 0, n;
    // Clock at 100 MHz
    always #5 pclk = ~pclk;
    dcfc_ctrl_cascade u_dcfc_ctrl_cascade (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .fifo_reset, .write_enable, .write_data,
        .write_parity, .read_enable, .read_data, .read_parity, .fifo_empty, .fifo_full,
        .write_reset_busy, .read_reset_busy, .write_error_flag, .read_error_flag,
        .write_level_count, .out_reg_clock_en(misc[0]), .out_reg_reset(misc[1]),
        .chain_data_in, .chain_parity_in, .chain_data_out, .chain_parity_out,
        .upstream_empty_in, .upstream_read_req, .downstream_read_req(misc[2]),
        .downstream_empty_out, .outreg_mux_sel_d(misc[3]), .outreg_mux_sel_en(misc[4]),
        .ram_mux_sel_d(misc[5]), .ram_mux_sel_en(misc[6]));
    dcfc_up_model u_dcfc_up_model (.pclk, .presetn, .upstream_read_req, .chain_data_in,
        .chain_parity_in, .upstream_empty_in);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Cascade and output-stage controls wander at random; modes that do not use them must ignore them
    always @(posedge pclk) misc <= 7'(xs());
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Waits for pready as long as it takes; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // One pulse on a request line, checked the cycle after it is sampled
    task automatic pulse(input bit wr);
        @(posedge pclk);
        if (wr) write_enable <= 1; else read_enable <= 1;
        @(posedge pclk);
        {write_enable, read_enable} <= 2'b00;
        #1;
    endtask
    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge pclk);
        chk("wr_busy_rst", write_reset_busy, 1);
        chk("rd_busy_rst", read_reset_busy, 1);
        presetn <= 1;
        write_enable <= 1;
        @(posedge pclk);
        #1;
        write_enable <= 0;
        chk("wr_err_busy", write_error_flag, 1);
        for (n = 1; write_reset_busy !== 1'b0 && n < 20; n++) @(posedge pclk) #1;
        chk("wr_busy_len", n, dcfc_pkg::WR_BUSY_CYC);
        for (n = 0; read_reset_busy !== 1'b0 && n < 20; n++) @(posedge pclk) #1;
        chk("rd_busy_tail", n, dcfc_pkg::RD_TAIL_CYC);
        // Back-to-back random writes
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            words[i] = {xs(), xs()};
            {write_enable, write_data, write_parity} <= {1'b1, words[i], words[i][7:0]};
        end
        @(posedge pclk);
        write_enable <= 0;
        repeat (2) @(posedge pclk) #1;
        chk("ptr", write_level_count, 4);
        apb(1, dcfc_pkg::CTRL_OFF, 32'h0000_0002);
        repeat (2) @(posedge pclk) #1;
        chk("count", write_level_count, 4);
        for (int i = 0; i < 4; i++) begin
            pulse(0);
            chk("rdata", read_data, words[i]);
            chk("rparity", read_parity, words[i][7:0]);
        end
        pulse(0);
        chk("rd_err_empty", read_error_flag, 1);
        chk("count_empty", {write_level_count, fifo_empty}, 15'h0001);
        chk("chain_out", {chain_parity_out, downstream_empty_out, upstream_read_req}, 10'h002);
        chk("chain_dout0", chain_data_out, 64'h0);
        apb(0, 8'h3C, 32'h0);
        chk("unmapped", {err, rd}, 33'h1_0000_0000);
        apb(1, dcfc_pkg::CTRL_OFF, 32'h0000_0001);
        pulse(1);
        chk("wr_err_sleep", write_error_flag, 1);
        @(posedge pclk);
        fifo_reset <= 1;
        @(posedge pclk);
        fifo_reset <= 0;
        pulse(0);
        chk("rd_err_busy", {read_reset_busy, read_error_flag}, 3);
        repeat (10) @(posedge pclk);
        apb(1, dcfc_pkg::CTRL_OFF, {27'h0, dcfc_pkg::POS_LAST, 2'b00});
        repeat (10) @(posedge pclk);
        apb(0, dcfc_pkg::CNT_OFF, 32'h0);
        chk("chain_pull", {rd[29:16], upstream_read_req}, 14'h3 << 1);
        pulse(0);
        chk("chain_word", read_data, 64'hC0DE_0000_0000_0003);
        // Fill to the brim; two chained words are still inside
        apb(1, dcfc_pkg::CTRL_OFF, 32'h0000_0000);
        write_enable <= 1;
        repeat (520) @(posedge pclk);
        #1;
        write_enable <= 0;
        chk("full", {fifo_full, write_error_flag}, 2'h3);
        // Serial source, registered: the random next-FIFO requests drain it
        apb(1, dcfc_pkg::CTRL_OFF, {25'h0, dcfc_pkg::MODE_REG, dcfc_pkg::POS_FIRST, 2'b00});
        #1;
        chk("ds_empty", downstream_empty_out, 1'b0);
        repeat (30) @(posedge pclk);
        #1;
        chk("ds_full", fifo_full, 1'b0);
        chk("ds_rdata", read_data, words[3]);
        chk("chain_dout", chain_data_out, words[3]);
        chk("chain_pout", chain_parity_out, words[3][7:0]);
        // Pipelined parallel: wait for a reset pulse on a loaded stage
        apb(1, dcfc_pkg::CTRL_OFF, {25'h0, dcfc_pkg::MODE_PIPE, dcfc_pkg::POS_PARALLEL, 2'b00});
        for (n = 0; n < 40; n++) begin
            @(posedge pclk);
            #1;
            if (misc[1] && read_data != 64'h0) break;
        end
        @(posedge pclk);
        #1;
        chk("pipe_rst", read_data, 64'h0);
        finish_test();
    end
endmodule // tb_dcfc_ctrl_cascade
`default_nettype wire
